// ---- core/amplifier_redundancy_control.sv ----
// Redundancy controller: role, switchover, offsets and command replies
// Contract
// RL1: Role comes from cable type and connector position sensed on the loop.
// RL2: In 1:1, the unit not selected by the switch is the backup.
// RL3: Auto mode: healthy backup takes over on active comm loss or fault.
// RL4: Manual mode: no switchover on faults.
// RL5: Controller writes the same mode to both units of a pair.
// RL6: Switch command 1 puts unit one online, 2 puts unit two online.
// RL7: 1:1 backup stores gain offset and loads it when taking over.
// RL8: 1:2 backup monitors both online units for comm and summary faults.
// RL9: Backup adopts the faulted unit's last good status before going online.
// RL10: After takeover mode becomes manual; backup stays online until reset. In 1:1 the code lets a switch command take it offline.
// RL11: Force value 0 returns to auto with units one and two online.
// RL12: Force value 1 replaces unit one, value 2 replaces unit two.
// RL13: 1:2 backup keeps one stored offset per online unit.
// RL14: Forced replacement applies the stored offset of that unit.
// RL15: Attenuation command retunes while standing in; rewrite stores tuned value.
// RL16: Replies carry one of five qualifiers.
// RL17: Communication loss timeout is a parameter.
`timescale 1ns/1ps
`include "redundancy_defs.svh"
module amplifier_redundancy_control
    import redundancy_pkg::*;
#(
    parameter int ATT_W = 8,
    parameter int CFG_W = 16,
    parameter int TIMEOUT_CYC = `COMM_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [1:0] cableType,
    input wire logic [1:0] cablePosition,
    input wire logic remoteEnabled,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic [1:0] cmdIndex,
    input wire logic [ATT_W-1:0] cmdValue,
    input wire logic ownSumFault,
    input wire logic [1:0] peerAlive,
    input wire logic [1:0] peerSumFault,
    input wire logic [2*CFG_W-1:0] peerCfg,
    output logic replyValid,
    output logic [2:0] replyCode,
    output logic [1:0] role,
    output logic autoMode,
    output logic online,
    output logic [1:0] switch_position_select,
    output logic [1:0] force_backup_select,
    output logic [ATT_W-1:0] attenuation_setting,
    output logic [CFG_W-1:0] activeCfg,
    output logic [1:0] peerFault
);
    role_e role_r;
    logic mode_r;
    logic [1:0] switch_r;
    logic [1:0] force_r;
    logic online_r;
    logic [ATT_W-1:0] atten_r;
    logic [ATT_W-1:0] pair_gain_offset_r;
    logic [ATT_W-1:0] standby_offset_per_unit_r [2];
    logic [CFG_W-1:0] cfg_r;
    logic replyValid_r;
    logic [2:0] replyCode_r;
    logic [1:0] commLost;
    logic [1:0] faulted;
    logic [CFG_W-1:0] lastGood [2];
    logic isOneOne;
    logic isOneTwo;
    logic isBackup;
    logic takeover;
    logic takeIdx;
    logic argOk;
    logic permitted;
    cmd_e cmd;

    assign isOneOne = cableType == 2'(CABLE_ONE_ONE);
    assign isOneTwo = cableType == 2'(CABLE_ONE_TWO);
    assign cmd = cmd_e'(cmdCode);

    // Role from cable type and connector position
    always_ff @(posedge core_clk) begin
        if (reset) begin
            role_r <= ROLE_NONE;
        end else if (clkEn) begin
            if (isOneTwo) begin
                role_r <= role_e'(cablePosition); // RL1
            end else if (isOneOne && cablePosition == 2'(ROLE_UNIT1)) begin
                role_r <= ROLE_UNIT1; // RL1
            end else if (isOneOne && cablePosition == 2'(ROLE_UNIT2)) begin
                role_r <= ROLE_UNIT2; // RL1
            end else begin
                role_r <= ROLE_NONE;
            end
        end
    end

    // In 1:1 the backup is whichever unit the switch does not select
    always_comb begin
        if (isOneOne) begin
            isBackup = (role_r == ROLE_UNIT1 && switch_r == `SWITCH_UNIT2) ||
                       (role_r == ROLE_UNIT2 && switch_r == `SWITCH_UNIT1); // RL2
        end else begin
            isBackup = isOneTwo && role_r == ROLE_BACKUP;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gPeer
            peer_monitor #(.CFG_W(CFG_W), .TIMEOUT_CYC(TIMEOUT_CYC)) uMon (
                .core_clk(core_clk),
                .reset(reset),
                .clkEn(clkEn),
                .enable(isBackup && !online_r && (isOneTwo || g == 0)), // RL8
                .peerAlive(peerAlive[g]),
                .peerSumFault(peerSumFault[g]),
                .peerCfg(peerCfg[g*CFG_W +: CFG_W]),
                .commLost(commLost[g]),
                .faulted(faulted[g]),
                .lastGoodCfg(lastGood[g])
            );
        end
    endgenerate

    // Automatic takeover only by a healthy backup in auto mode
    assign takeover = clkEn && mode_r == `MODE_AUTO && isBackup && !online_r && !ownSumFault &&
                      (faulted != 2'b00); // RL3 RL4
    assign takeIdx = !faulted[0];

    always_comb begin
        argOk = 1'b1;
        permitted = 1'b1;
        case (cmd)
            CMD_MODE: argOk = cmdValue <= ATT_W'(1);
            CMD_SWITCH: begin
                argOk = cmdValue == ATT_W'(1) || cmdValue == ATT_W'(2);
                permitted = isOneOne && mode_r == `MODE_MANUAL;
            end
            CMD_GAIN_OFFSET: permitted = isOneOne;
            CMD_FORCE: begin
                argOk = cmdValue <= ATT_W'(2);
                permitted = isOneTwo && role_r == ROLE_BACKUP; // RL12
            end
            CMD_STANDBY_OFFSET: begin
                argOk = cmdIndex == 2'h1 || cmdIndex == 2'h2;
                permitted = isOneTwo && role_r == ROLE_BACKUP;
            end
            CMD_ATTEN: argOk = 1'b1;
            default: argOk = 1'b0;
        endcase
    end

    wire logic accept = clkEn && cmdValid && remoteEnabled && cmd != CMD_NONE && argOk && permitted;

    // Reply qualifier for each command
    always_ff @(posedge core_clk) begin
        if (reset) begin
            replyValid_r <= 1'b0;
            replyCode_r <= 3'(REPLY_OK);
        end else if (clkEn) begin
            replyValid_r <= cmdValid;
            if (cmd == CMD_NONE || cmdCode > 3'(CMD_ATTEN)) begin
                replyCode_r <= 3'(REPLY_BAD_INSTR); // RL16
            end else if (!remoteEnabled) begin
                replyCode_r <= 3'(REPLY_NOT_REMOTE); // RL16
            end else if (!argOk) begin
                replyCode_r <= 3'(REPLY_BAD_ARGS); // RL16
            end else if (!permitted) begin
                replyCode_r <= 3'(REPLY_NOT_PERMITTED); // RL16
            end else begin
                replyCode_r <= 3'(REPLY_OK); // RL16
            end
        end
    end

    // Redundancy mode
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_r <= `MODE_MANUAL;
        end else if (takeover) begin
            mode_r <= `MODE_MANUAL; // RL10
        end else if (accept && cmd == CMD_MODE) begin
            mode_r <= cmdValue[0]; // RL5
        end else if (accept && cmd == CMD_FORCE) begin
            mode_r <= cmdValue[1:0] == `FORCE_NONE; // RL11
        end
    end

    // Waveguide switch position and forced backup selection
    always_ff @(posedge core_clk) begin
        if (reset) begin
            switch_r <= `SWITCH_UNIT1;
            force_r <= `FORCE_NONE;
        end else if (takeover) begin
            if (isOneOne) begin
                switch_r <= (role_r == ROLE_UNIT1) ? `SWITCH_UNIT1 : `SWITCH_UNIT2; // RL3
            end else begin
                force_r <= takeIdx ? `FORCE_UNIT2 : `FORCE_UNIT1; // RL8
            end
        end else if (accept && cmd == CMD_SWITCH) begin
            switch_r <= cmdValue[1:0]; // RL6
        end else if (accept && cmd == CMD_FORCE) begin
            force_r <= cmdValue[1:0]; // RL12
        end
    end

    // Online state: 1:2 backup holds online until the user force-resets; in 1:1 a switch command can take it offline
    always_ff @(posedge core_clk) begin
        if (reset) begin
            online_r <= 1'b0;
        end else if (clkEn) begin
            if (takeover) begin
                online_r <= 1'b1; // RL10
            end else if (accept && cmd == CMD_FORCE) begin
                online_r <= cmdValue[1:0] != `FORCE_NONE; // RL11
            end else if (role_r == ROLE_NONE) begin
                // No role until the cable is sensed, so never online straight after reset
                online_r <= 1'b0;
            end else if (isOneOne) begin
                online_r <= !isBackup;
            end else if (isOneTwo && role_r != ROLE_BACKUP) begin
                online_r <= 1'b1;
            end
        end
    end

    // Stored offsets
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pair_gain_offset_r <= ATT_W'(`ATTEN_RESET);
            standby_offset_per_unit_r[0] <= ATT_W'(`ATTEN_RESET);
            standby_offset_per_unit_r[1] <= ATT_W'(`ATTEN_RESET);
        end else if (accept && cmd == CMD_GAIN_OFFSET) begin
            pair_gain_offset_r <= cmdValue; // RL7
        end else if (accept && cmd == CMD_STANDBY_OFFSET) begin
            standby_offset_per_unit_r[cmdIndex[1]] <= cmdValue; // RL13 RL15
        end
    end

    // Attenuation applied on takeover, forced replacement or direct command
    always_ff @(posedge core_clk) begin
        if (reset) begin
            atten_r <= ATT_W'(`ATTEN_RESET);
        end else if (takeover) begin
            atten_r <= isOneOne ? pair_gain_offset_r : standby_offset_per_unit_r[takeIdx]; // RL7 RL14
        end else if (accept && cmd == CMD_FORCE && cmdValue[1:0] != `FORCE_NONE) begin
            atten_r <= standby_offset_per_unit_r[cmdValue[1]]; // RL14
        end else if (accept && cmd == CMD_ATTEN) begin
            atten_r <= cmdValue; // RL15
        end
    end

    // Configuration adopted from the replaced unit
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg_r <= CFG_W'(`CFG_RESET);
        end else if (takeover) begin
            cfg_r <= lastGood[isOneOne ? 1'b0 : takeIdx]; // RL9
        end else if (accept && cmd == CMD_FORCE && cmdValue[1:0] != `FORCE_NONE) begin
            cfg_r <= lastGood[cmdValue[1]]; // RL9
        end
    end

    assign replyValid = replyValid_r;
    assign replyCode = replyCode_r;
    assign role = role_r;
    assign autoMode = mode_r;
    assign online = online_r;
    assign switch_position_select = switch_r;
    assign force_backup_select = force_r;
    assign attenuation_setting = atten_r;
    assign activeCfg = cfg_r;
    assign peerFault = faulted;
endmodule : amplifier_redundancy_control

// ---- core/redundancy_defs.svh ----
// Constants of the amplifier redundancy controller
`ifndef REDUNDANCY_DEFS_SVH
`define REDUNDANCY_DEFS_SVH
`define MODE_MANUAL 1'h0
`define MODE_AUTO 1'h1
`define SWITCH_UNIT1 2'h1
`define SWITCH_UNIT2 2'h2
`define FORCE_NONE 2'h0
`define FORCE_UNIT1 2'h1
`define FORCE_UNIT2 2'h2
`define CFG_RESET 16'h0000
`define ATTEN_RESET 8'h00
`define COMM_TIMEOUT_MS 100
`define CLK_HZ 20000000
`define COMM_TIMEOUT_CYC ((`COMM_TIMEOUT_MS * (`CLK_HZ / 1000)))
`endif

// ---- core/redundancy_pkg.sv ----
// Types of the amplifier redundancy controller
package redundancy_pkg;
    typedef enum logic [1:0] {ROLE_NONE, ROLE_UNIT1, ROLE_UNIT2, ROLE_BACKUP} role_e;
    typedef enum logic [1:0] {CABLE_NONE, CABLE_ONE_ONE, CABLE_ONE_TWO} cable_e;
    typedef enum logic [2:0] {
        REPLY_OK, REPLY_NOT_PERMITTED, REPLY_BAD_ARGS, REPLY_BAD_INSTR, REPLY_NOT_REMOTE
    } reply_e;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_MODE, CMD_SWITCH, CMD_GAIN_OFFSET, CMD_FORCE, CMD_STANDBY_OFFSET, CMD_ATTEN
    } cmd_e;
endpackage : redundancy_pkg

// ---- core/peer_monitor.sv ----
// Watchdog and last-good status capture for one peer unit
`timescale 1ns/1ps
`include "redundancy_defs.svh"
module peer_monitor
    import redundancy_pkg::*;
#(
    parameter int CFG_W = 16,
    parameter int TIMEOUT_CYC = `COMM_TIMEOUT_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic enable,
    input wire logic peerAlive,
    input wire logic peerSumFault,
    input wire logic [CFG_W-1:0] peerCfg,
    output logic commLost,
    output logic faulted,
    output logic [CFG_W-1:0] lastGoodCfg
);
    logic [31:0] silentCnt_r;
    logic commLost_r;
    logic [CFG_W-1:0] lastGood_r;

    // Missing responses count up to the timeout
    always_ff @(posedge core_clk) begin
        if (reset) begin
            silentCnt_r <= 32'h0000_0000;
            commLost_r <= 1'b0;
        end else if (clkEn) begin
            if (!enable || peerAlive) begin
                silentCnt_r <= 32'h0000_0000;
                commLost_r <= 1'b0;
            end else if (silentCnt_r >= 32'(TIMEOUT_CYC - 1)) begin
                commLost_r <= 1'b1; // RL17
            end else begin
                silentCnt_r <= silentCnt_r + 32'h0000_0001;
            end
        end
    end

    // Status is kept only while the peer is healthy
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lastGood_r <= CFG_W'(`CFG_RESET);
        end else if (clkEn && enable && peerAlive && !peerSumFault && !commLost_r) begin
            lastGood_r <= peerCfg; // RL9
        end
    end

    assign commLost = commLost_r;
    assign faulted = commLost_r | (enable & peerSumFault); // RL8
    assign lastGoodCfg = lastGood_r;
endmodule : peer_monitor

// ---- test/amplifier_redundancy_control_props.sv ----
// Port-level assertion checker for the redundancy controller
`timescale 1ns/1ps
module amplifier_redundancy_control_props
    import redundancy_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic [1:0] cableType,
    input wire logic remoteEnabled,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic [7:0] cmdValue,
    input wire logic ownSumFault,
    input wire logic replyValid,
    input wire logic [2:0] replyCode,
    input wire logic [1:0] role,
    input wire logic autoMode,
    input wire logic online,
    input wire logic [1:0] switch_position_select,
    input wire logic [1:0] force_backup_select,
    input wire logic [1:0] peerFault
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire fire = clkEn && cmdValid;
    wire autoTake = clkEn && autoMode && !online && cableType == 2'h2 && role == ROLE_BACKUP && peerFault != 2'h0
        && !ownSumFault;
    wire buCmd = fire && remoteEnabled && cableType == 2'h2 && role == ROLE_BACKUP && cmdCode == CMD_FORCE
        && !autoTake;
    reply_one_cycle_a: assert property (clkEn |=> replyValid == $past(fire))
        else $error("reply pulse does not follow the command");
    reply_bad_instr_a: assert property (fire && (cmdCode == 3'h0 || cmdCode == 3'h7) |=> replyCode == REPLY_BAD_INSTR)
        else $error("unknown code not refused");
    reply_not_remote_a: assert property (fire && cmdCode inside {[3'h1:3'h6]} && !remoteEnabled
        |=> replyCode == REPLY_NOT_REMOTE)
        else $error("local mode not reported");
    manual_hold_a: assert property (clkEn && !autoMode && !fire
        |=> $stable(switch_position_select) && $stable(force_backup_select))
        else $error("switch moved in manual mode");
    switch_cmd_a: assert property (fire && remoteEnabled && cableType == 2'h1 && !autoMode && cmdCode == CMD_SWITCH
        && cmdValue == 8'h01 |=> switch_position_select == 2'h1)
        else $error("switch command not applied");
    force_release_a: assert property (buCmd && cmdValue == 8'h00 |=> autoMode && !online && force_backup_select == 2'h0)
        else $error("force none did not restore auto");
    force_unit_a: assert property (buCmd && cmdValue == 8'h01 |=> online && !autoMode && force_backup_select == 2'h1)
        else $error("force unit one not applied");
    auto_takeover_a: assert property (clkEn && autoMode && cableType == 2'h2 && role == ROLE_BACKUP
        && peerFault != 2'h0 && !ownSumFault |=> online && !autoMode)
        else $error("backup did not take over");
    stay_online_a: assert property (clkEn && online && cableType == 2'h2 && !(fire && cmdCode == CMD_FORCE)
        |=> online)
        else $error("backup left without a force command");
endmodule : amplifier_redundancy_control_props
bind amplifier_redundancy_control amplifier_redundancy_control_props i_amplifier_redundancy_control_props (
    .core_clk, .reset, .clkEn, .cableType, .remoteEnabled, .cmdValid, .cmdCode, .cmdValue, .ownSumFault,
    .replyValid, .replyCode, .role, .autoMode, .online, .switch_position_select, .force_backup_select, .peerFault);

// ---- test/peer_unit_model.sv ----
// Behavioural peer amplifier unit
`timescale 1ns/1ps
module peer_unit_model #(
    parameter logic [15:0] STATUS = 16'h0000
) (
    input wire logic core_clk,
    input wire logic silent,
    input wire logic faulty,
    output logic alive,
    output logic sumFault,
    output logic [15:0] cfg
);
    // A silent unit stops answering and its status lines toggle every cycle
    always_ff @(posedge core_clk) begin
        alive <= !silent;
        sumFault <= faulty;
        cfg <= silent ? ~cfg : STATUS;
    end
endmodule : peer_unit_model

// ---- test/amplifier_redundancy_control_tb.sv ----
// Self-checking bench for the redundancy controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module amplifier_redundancy_control_tb;
    import redundancy_pkg::*;
    logic core_clk = 0, reset = 1, clkEn = 1, remoteEnabled = 1, cmdValid = 0, ownSumFault = 0;
    logic [1:0] cableType = 2'h2, cablePosition = 2'h3, cmdIndex = 2'h0, silent = 2'h0, faulty = 2'h0;
    logic [2:0] cmdCode = 3'h0;
    logic [7:0] cmdValue = 8'h00;
    logic [1:0] peerAlive, peerSumFault, role, switchSel, forceSel, peerFault;
    logic [31:0] peerCfg;
    logic replyValid, autoMode, online;
    logic [2:0] replyCode;
    logic [7:0] atten;
    logic [15:0] activeCfg;
    int error_cnt = 0, checks = 0, cycles = 0;
    initial forever #25 core_clk = ~core_clk;
    amplifier_redundancy_control #(.TIMEOUT_CYC(8)) i_amplifier_redundancy_control (.core_clk, .reset, .clkEn,
        .cableType, .cablePosition, .remoteEnabled, .cmdValid, .cmdCode, .cmdIndex, .cmdValue, .ownSumFault,
        .peerAlive, .peerSumFault, .peerCfg, .replyValid, .replyCode, .role, .autoMode, .online,
        .switch_position_select(switchSel), .force_backup_select(forceSel), .attenuation_setting(atten),
        .activeCfg, .peerFault);
    peer_unit_model #(.STATUS(16'h1a2b)) i_peer_unit_model_1 (.core_clk, .silent(silent[0]), .faulty(faulty[0]),
        .alive(peerAlive[0]), .sumFault(peerSumFault[0]), .cfg(peerCfg[15:0]));
    peer_unit_model #(.STATUS(16'h3c4d)) i_peer_unit_model_2 (.core_clk, .silent(silent[1]), .faulty(faulty[1]),
        .alive(peerAlive[1]), .sumFault(peerSumFault[1]), .cfg(peerCfg[31:16]));
    task automatic send(input logic [2:0] code, input logic [1:0] idx, input logic [7:0] val, input logic [2:0] exp);
        cmdCode = code;
        cmdIndex = idx;
        cmdValue = val;
        cmdValid = 1;
        @(negedge core_clk);
        `CHK("reply", {1'b1, exp}, {replyValid, replyCode})
        cmdValid = 0;
        @(negedge core_clk);
    endtask : send
    task automatic do_reset(input logic [1:0] cab, input logic [1:0] pos);
        cableType = cab;
        cablePosition = pos;
        reset = 1;
        repeat (6) @(negedge core_clk);
        reset = 0;
        repeat (2) @(negedge core_clk);
        `CHK("role", cab == 2'h2 ? ROLE_BACKUP : ROLE_UNIT1, role)
    endtask : do_reset
    task automatic wait_online(input int n);
        for (int i = 0; i < n && online !== 1'b1; i++) @(negedge core_clk);
    endtask : wait_online
    task automatic test_refusals;
        send(3'h0, 2'h0, 8'h00, REPLY_BAD_INSTR);
        send(3'h7, 2'h0, 8'h00, REPLY_BAD_INSTR);
        send(CMD_SWITCH, 2'h0, 8'h01, REPLY_NOT_PERMITTED);
        send(CMD_GAIN_OFFSET, 2'h0, 8'h01, REPLY_NOT_PERMITTED);
        send(CMD_FORCE, 2'h0, 8'h05, REPLY_BAD_ARGS);
        remoteEnabled = 0;
        send(CMD_FORCE, 2'h0, 8'h01, REPLY_NOT_REMOTE);
        remoteEnabled = 1;
        clkEn = 0;
        cmdCode = CMD_ATTEN;
        cmdValue = 8'h55;
        cmdValid = 1;
        @(negedge core_clk);
        cmdValid = 0;
        clkEn = 1;
        `CHK("freeze", 9'h000, {replyValid, atten})
        @(negedge core_clk);
        `CHK("refused", 1'b0, online)
        $display("test_refusals done");
    endtask : test_refusals
    task automatic test_force_offsets;
        send(CMD_STANDBY_OFFSET, 2'h1, 8'h3c, REPLY_OK);
        send(CMD_STANDBY_OFFSET, 2'h2, 8'h28, REPLY_OK);
        send(CMD_FORCE, 2'h0, 8'h01, REPLY_OK);
        `CHK("force1", {4'h9, 8'h3c, 16'h1a2b}, {online, autoMode, forceSel, atten, activeCfg})
        send(CMD_ATTEN, 2'h0, 8'h40, REPLY_OK);
        `CHK("tune", 8'h40, atten)
        send(CMD_STANDBY_OFFSET, 2'h1, 8'h40, REPLY_OK);
        send(CMD_FORCE, 2'h0, 8'h02, REPLY_OK);
        `CHK("force2", {2'h2, 8'h28, 16'h3c4d}, {forceSel, atten, activeCfg})
        send(CMD_FORCE, 2'h0, 8'h00, REPLY_OK);
        `CHK("release", 4'h4, {online, autoMode, forceSel})
        send(CMD_FORCE, 2'h0, 8'h01, REPLY_OK);
        `CHK("stored", 8'h40, atten)
        send(CMD_FORCE, 2'h0, 8'h00, REPLY_OK);
        $display("test_force_offsets done");
    endtask : test_force_offsets
    task automatic test_auto_takeover;
        faulty = 2'h2;
        wait_online(6);
        `CHK("take", {4'ha, 8'h28, 16'h3c4d}, {online, autoMode, forceSel, atten, activeCfg})
        repeat (5) @(negedge core_clk);
        `CHK("stay", 1'b1, online)
        faulty = 2'h0;
        send(CMD_FORCE, 2'h0, 8'h00, REPLY_OK);
        silent = 2'h1;
        repeat (6) @(negedge core_clk);
        `CHK("early", 1'b0, online)
        wait_online(8);
        `CHK("lost", {1'b1, 2'h1, 8'h40, 16'h1a2b}, {online, forceSel, atten, activeCfg})
        silent = 2'h0;
        $display("test_auto_takeover done");
    endtask : test_auto_takeover
    task automatic test_one_one;
        do_reset(2'h1, 2'h1);
        send(CMD_MODE, 2'h0, 8'h00, REPLY_OK);
        send(CMD_SWITCH, 2'h0, 8'h01, REPLY_OK);
        `CHK("sw1", 3'h3, {switchSel, online})
        send(CMD_SWITCH, 2'h0, 8'h02, REPLY_OK);
        `CHK("sw2", 3'h4, {switchSel, online})
        send(CMD_GAIN_OFFSET, 2'h0, 8'h14, REPLY_OK);
        faulty = 2'h1;
        repeat (8) @(negedge core_clk);
        `CHK("manual", 3'h1, {online, peerFault})
        send(CMD_MODE, 2'h0, 8'h01, REPLY_OK);
        wait_online(6);
        `CHK("take11", {4'h9, 8'h14}, {online, autoMode, switchSel, atten})
        faulty = 2'h0;
        $display("test_one_one done");
    endtask : test_one_one
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        do_reset(2'h2, 2'h3);
        test_refusals;
        test_force_offsets;
        test_auto_takeover;
        test_one_one;
        end_of_test;
    end
    initial forever begin
        @(posedge core_clk);
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            end_of_test;
        end
    end
endmodule : amplifier_redundancy_control_tb
